// *** common/ddr3_core_pkg.sv ***
// How it works
// - commands decode from cs, ras, cas, we and cke at rising ck
// - deselect and nop start nothing and leave running work alone
// - short calibration runs 64 ck cycles, then applies the new code
// - activate opens the addressed row in the selected bank until precharge
// - read bursts from an open row, start column from a[2:0] and type
// - read with a10 high closes the row when its burst ends
// - with on-the-fly enabled a12 low picks chop four, high eight
// - a started read burst always completes, later commands cannot stop it
// - write bursts into the open row of the bank, a10 picks precharge
// - write beat bytes with mask low are stored, mask high left unchanged
// - precharge closes one bank with a10 low, all banks with a10 high
// - precharge to idle bank acts as nop but restarts the precharge timer
// - reads or writes to other banks accepted during an auto precharge
// - refresh uses the internal row counter, one step per command
// - self refresh keeps data on its own with the clock stopped
package ddr3_core_pkg;

	// geometry
	localparam int NUM_BANKS = 8;
	localparam int BA_W = 3;
	localparam int ADDR_W = 16;
	localparam int COL_W = 10;
	localparam int DQ_W = 16;
	localparam int DM_W = 2;
	localparam int A10_POS = 10;
	localparam int A12_POS = 12;

	// timing
	localparam int CORE_PERIOD_NS = 10;
	localparam int T_REFI_NS = 7800;
	localparam int SREF_INTERVAL_CYC = T_REFI_NS / CORE_PERIOD_NS;
	localparam int SREF_CNT_W = $clog2(SREF_INTERVAL_CYC);
	localparam int ZQCS_CK_CYC = 64;
	localparam int ZQ_CNT_W = $clog2(ZQCS_CK_CYC);
	localparam int TRP_CK_DEF = 11;
	localparam int PRE_W = 8;

	// burst and reset values
	localparam logic [2:0] BL8_LAST = 3'h7;
	localparam logic [2:0] BC4_LAST = 3'h3;
	localparam logic [7:0] ZQ_CODE_RST = 8'h80;
	localparam int REF_ROW_W = 13;
	localparam int SELF_REF_BIT = 3;

	// pins as sampled from the controller
	typedef struct packed {
		logic ck;
		logic cke;
		logic cs_b;
		logic ras_b;
		logic cas_b;
		logic we_b;
		logic [BA_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
		logic [DQ_W-1:0] dq;
		logic [DM_W-1:0] dm;
		logic zq_hi;
	} pins_t;

	// one read beat into the output buffer
	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic last;
	} rd_beat_t;

	typedef enum logic [3:0] {
		BURST_IDLE = 4'h1,
		BURST_RD = 4'h2,
		BURST_WR = 4'h4,
		SELF_REF = 4'h8
	} mode_t;

	typedef enum logic [2:0] {
		CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_SRE, CMD_ZQCS
	} cmd_t;

	// column of beat n given the start column, chop and burst type
	function automatic logic [2:0] col_order(input logic [2:0] start,
		input logic [2:0] beat, input logic bc4, input logic ilv);
		if (ilv)
			return start ^ beat;
		else if (bc4)
			return {start[2], start[1:0] + beat[1:0]};
		else
			return start + beat;
	endfunction

endpackage

// *** rtl/pair_buffer.sv ***
`timescale 1ns/10ps
module pair_buffer #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);

	typedef struct packed {
		logic [DEPTH-1:0] vld;
		logic [DEPTH-1:0][W-1:0] ent;
	} buf_state_t;

	buf_state_t q;
	buf_state_t n;

	////////////////////////////////////////////////////////////////////////
	// shift register queue: head always in entry 0, so outputs are flops
	always_comb
	begin
		logic placed;
		placed = 1'b0;
		n = q;
		if (out_ready_i && q.vld[0])
		begin
			n.vld = q.vld >> 1;
			for (int i = 0; i < DEPTH - 1; i++)
				n.ent[i] = q.ent[i+1];
			n.ent[DEPTH-1] = '0;
		end
		if (in_valid_i && !q.vld[DEPTH-1])
		begin
			for (int i = 0; i < DEPTH; i++)
				if (!placed && !n.vld[i])
				begin
					n.vld[i] = 1'b1;
					n.ent[i] = in_data_i;
					placed = 1'b1;
				end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			q <= '0;
		else
			q <= n;
	end

	assign in_ready_o = !q.vld[DEPTH-1]; // full only when last slot taken
	assign out_valid_o = q.vld[0];
	assign out_data_o = q.ent[0];

endmodule

// *** rtl/ddr3_core_cmd.sv ***
`timescale 1ns/10ps
module ddr3_core_cmd import ddr3_core_pkg::*; #(
	parameter int TRP_CK = TRP_CK_DEF,
	parameter int ROW_KEEP_W = 2,
	parameter int COL_KEEP_W = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// command and data pins from the controller
	input wire logic ck_i,
	input wire logic cke_i,
	input wire logic cs_b_i,
	input wire logic ras_b_i,
	input wire logic cas_b_i,
	input wire logic we_b_i,
	input wire logic [BA_W-1:0] ba_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DQ_W-1:0] dq_i,
	input wire logic [DM_W-1:0] dm_i,
	// calibration comparator pin
	input wire logic zq_hi_i,
	// static mode settings
	input wire logic otf_en_i,
	input wire logic bc4_fixed_i,
	input wire logic burst_ilv_i,
	// read data stream
	output logic [DQ_W-1:0] rd_data_o,
	output logic rd_last_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	// status
	output logic [NUM_BANKS-1:0] bank_open_o,
	output logic self_ref_o,
	output logic zq_busy_o,
	output logic [7:0] zq_code_o,
	output logic [REF_ROW_W-1:0] refresh_row_o,
	output logic cmd_err_o
);

	localparam int IDX_W = BA_W + ROW_KEEP_W + COL_KEEP_W;
	localparam int MEM_DEPTH = 1 << IDX_W;
	localparam int BYTE_W = DQ_W / DM_W;

	typedef struct packed {
		pins_t s1;
		pins_t s2;
		logic ck_prev;
		logic cke_prev;
		mode_t mode;
		logic [NUM_BANKS-1:0] open;
		logic [NUM_BANKS-1:0][ADDR_W-1:0] row;
		logic [NUM_BANKS-1:0][PRE_W-1:0] prech_cnt;
		logic [BA_W-1:0] burst_bank;
		logic burst_ap;
		logic burst_bc4;
		logic burst_ilv;
		logic [COL_W-1:0] burst_col;
		logic [2:0] beat;
		logic zq_busy;
		logic [ZQ_CNT_W-1:0] zq_cnt;
		logic [7:0] zq_work;
		logic [7:0] zq_code;
		logic [REF_ROW_W-1:0] ref_row;
		logic [SREF_CNT_W-1:0] sref_cnt;
		logic cmd_err;
	} core_t;

	core_t q;
	core_t n;
	pins_t pins_now;
	cmd_t cmd;
	logic ev;
	logic rd_push;
	rd_beat_t rd_beat;
	logic buf_ready;
	rd_beat_t buf_out;
	logic close_any;
	logic mem_we;
	logic [IDX_W-1:0] wr_idx;
	logic [DQ_W-1:0] wr_data;
	logic [DM_W-1:0] wr_mask;
	logic [IDX_W-1:0] rd_idx;
	logic [DQ_W-1:0] mem [MEM_DEPTH];

	////////////////////////////////////////////////////////////////////////
	// helpers

	// command from pins at a rising ck, cke of the previous edge given
	function automatic cmd_t decode_cmd(input pins_t p, input logic cke_pre);
		if (!cke_pre || p.cs_b)
			return CMD_NONE; // deselect or clock suspended
		case ({p.ras_b, p.cas_b, p.we_b})
			3'h3: return p.cke ? CMD_ACT : CMD_NONE;
			3'h5: return CMD_RD;
			3'h4: return CMD_WR;
			3'h2: return p.cke ? CMD_PRE : CMD_NONE;
			3'h1: return p.cke ? CMD_REF : CMD_SRE;
			3'h6: return p.addr[A10_POS] ? CMD_NONE : CMD_ZQCS;
			default: return CMD_NONE;
		endcase
	endfunction

	// array slot of a bank, row and column (only low row/column bits kept)
	function automatic logic [IDX_W-1:0] mem_index(input logic [BA_W-1:0] b,
		input logic [ADDR_W-1:0] r, input logic [COL_W-1:0] c);
		return {b, r[ROW_KEEP_W-1:0], c[COL_KEEP_W-1:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pins bundled for the two flop synchroniser
	assign pins_now = '{ck: ck_i, cke: cke_i, cs_b: cs_b_i, ras_b: ras_b_i,
		cas_b: cas_b_i, we_b: we_b_i, ba: ba_i, addr: addr_i, dq: dq_i,
		dm: dm_i, zq_hi: zq_hi_i};

	// rising ck seen on the synchronised copy
	assign ev = q.s2.ck && !q.ck_prev;
	assign cmd = ev ? decode_cmd(q.s2, q.cke_prev) : CMD_NONE;

	// current read beat address and data
	assign rd_idx = mem_index(q.burst_bank, q.row[q.burst_bank],
		{q.burst_col[COL_W-1:3], col_order(q.burst_col[2:0], q.beat,
		q.burst_bc4, q.burst_ilv)});
	assign rd_beat.data = mem[rd_idx];
	assign rd_beat.last = (q.beat == (q.burst_bc4 ? BC4_LAST : BL8_LAST));

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		logic [BA_W-1:0] ba;
		ba = q.s2.ba;
		n = q;
		rd_push = 1'b0;
		close_any = 1'b0;
		mem_we = 1'b0;
		wr_idx = '0;
		wr_data = q.s2.dq;
		wr_mask = '0;
		n.s1 = pins_now;
		n.s2 = q.s1;
		n.ck_prev = q.s2.ck;

		// per ck edge: cke history and precharge timers
		if (ev)
		begin
			n.cke_prev = q.s2.cke;
			for (int b = 0; b < NUM_BANKS; b++)
				if (q.prech_cnt[b] != '0)
					n.prech_cnt[b] = q.prech_cnt[b] - 1'b1;
		end

		// short calibration, one step per ck edge
		if (ev && q.zq_busy)
		begin
			if (q.s2.zq_hi && q.zq_work != 8'hFF)
				n.zq_work = q.zq_work + 8'h01;
			else if (!q.s2.zq_hi && q.zq_work != 8'h00)
				n.zq_work = q.zq_work - 8'h01;
			n.zq_cnt = q.zq_cnt + 1'b1;
			if (q.zq_cnt == ZQ_CNT_W'(ZQCS_CK_CYC - 1))
			begin
				n.zq_busy = 1'b0;
				n.zq_code = n.zq_work;
			end
		end

		// burst engine; deselect and nop never reach it
		case (q.mode)
			BURST_RD:
			begin
				if (buf_ready)
				begin
					rd_push = 1'b1;
					n.beat = q.beat + 3'h1;
					if (rd_beat.last)
					begin
						n.mode = BURST_IDLE;
						if (q.burst_ap)
						begin
							n.open[q.burst_bank] = 1'b0;
							n.prech_cnt[q.burst_bank] = PRE_W'(TRP_CK);
							close_any = 1'b1;
						end
					end
				end
			end
			BURST_WR:
			begin
				if (ev)
				begin
					mem_we = 1'b1;
					wr_mask = ~q.s2.dm;
					wr_idx = mem_index(q.burst_bank, q.row[q.burst_bank],
						{q.burst_col[COL_W-1:3], col_order(q.burst_col[2:0],
						q.beat, q.burst_bc4, q.burst_ilv)});
					n.beat = q.beat + 3'h1;
					if (q.beat == (q.burst_bc4 ? BC4_LAST : BL8_LAST))
					begin
						n.mode = BURST_IDLE;
						if (q.burst_ap)
						begin
							n.open[q.burst_bank] = 1'b0;
							n.prech_cnt[q.burst_bank] = PRE_W'(TRP_CK);
							close_any = 1'b1;
						end
					end
				end
			end
			SELF_REF:
			begin
				// own timer on the core clock, ck may be stopped
				n.sref_cnt = q.sref_cnt + 1'b1;
				if (q.sref_cnt == SREF_CNT_W'(SREF_INTERVAL_CYC - 1))
				begin
					n.sref_cnt = '0;
					n.ref_row = q.ref_row + 1'b1;
				end
				if (q.s2.cke)
				begin
					n.mode = BURST_IDLE;
					n.cke_prev = 1'b1;
				end
			end
			BURST_IDLE:
			begin
			end
			default: n.mode = BURST_IDLE;
		endcase

		// commands from this ck edge
		case (cmd)
			CMD_ACT:
			begin
				if (q.open[ba] || q.prech_cnt[ba] != '0)
					n.cmd_err = 1'b1;
				else
				begin
					n.open[ba] = 1'b1;
					n.row[ba] = q.s2.addr;
				end
			end
			CMD_RD, CMD_WR:
			begin
				// other bank allowed while one auto precharges
				if (!n.open[ba] || n.mode != BURST_IDLE)
					n.cmd_err = 1'b1;
				else
				begin
					n.mode = (cmd == CMD_RD) ? BURST_RD : BURST_WR;
					n.burst_bank = ba;
					n.burst_ap = q.s2.addr[A10_POS];
					n.burst_bc4 = otf_en_i ? !q.s2.addr[A12_POS] :
						bc4_fixed_i;
					n.burst_ilv = burst_ilv_i;
					n.burst_col = q.s2.addr[COL_W-1:0];
					n.beat = 3'h0;
				end
			end
			CMD_PRE:
			begin
				for (int b = 0; b < NUM_BANKS; b++)
					if (q.s2.addr[A10_POS] || ba == BA_W'(b))
					begin
						if (n.mode != BURST_IDLE && q.burst_bank == BA_W'(b))
							n.burst_ap = 1'b1; // close after the burst
						else
						begin
							close_any = close_any || n.open[b];
							n.open[b] = 1'b0;
							n.prech_cnt[b] = PRE_W'(TRP_CK);
						end
					end
			end
			CMD_REF:
			begin
				if (n.open != '0 || n.mode != BURST_IDLE)
					n.cmd_err = 1'b1;
				n.ref_row = q.ref_row + 1'b1;
			end
			CMD_SRE:
			begin
				if (n.open != '0 || n.mode != BURST_IDLE)
					n.cmd_err = 1'b1;
				else
				begin
					n.mode = SELF_REF;
					n.sref_cnt = '0;
					n.ref_row = q.ref_row + 1'b1;
				end
			end
			CMD_ZQCS:
			begin
				if (!q.zq_busy)
				begin
					n.zq_busy = 1'b1;
					n.zq_cnt = '0;
					n.zq_work = q.zq_code;
				end
			end
			// deselect, nop and unused codes leave every state alone
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			q <= '0;
			q.mode <= BURST_IDLE;
			q.zq_code <= ZQ_CODE_RST;
			q.zq_work <= ZQ_CODE_RST;
		end
		else
			q <= n;
	end

	// storage array, byte lanes written only where mask is low
	always_ff @(posedge core_clk_i)
	begin
		if (mem_we)
			for (int l = 0; l < DM_W; l++)
				if (wr_mask[l])
					mem[wr_idx][l*BYTE_W +: BYTE_W] <=
						wr_data[l*BYTE_W +: BYTE_W];
	end

	////////////////////////////////////////////////////////////////////////
	// read buffer; a stalled receiver holds the burst engine
	pair_buffer #(
		.W($bits(rd_beat_t)),
		.DEPTH(2)
	) u_rd_buf (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(rd_push),
		.in_data_i(rd_beat),
		.in_ready_o(buf_ready),
		.out_valid_o(rd_valid_o),
		.out_data_o(buf_out),
		.out_ready_i(rd_ready_i)
	);

	// outputs straight from flops
	assign rd_data_o = buf_out.data;
	assign rd_last_o = buf_out.last;
	assign bank_open_o = q.open;
	assign self_ref_o = q.mode[SELF_REF_BIT];
	assign zq_busy_o = q.zq_busy;
	assign zq_code_o = q.zq_code;
	assign refresh_row_o = q.ref_row;
	assign cmd_err_o = q.cmd_err;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_zq_length: assert property ($fell(q.zq_busy) |->
		$past(q.zq_cnt) == ZQ_CNT_W'(ZQCS_CK_CYC - 1))
		else $error("calibration ended at wrong count");
	chk_zq_code_hold: assert property ((q.zq_busy && $past(q.zq_busy)) |->
		$stable(q.zq_code))
		else $error("code changed during calibration");
	chk_act_opens: assert property ((cmd == CMD_ACT && !q.open[q.s2.ba] &&
		q.prech_cnt[q.s2.ba] == '0) |=> (q.open[$past(q.s2.ba)] &&
		q.row[$past(q.s2.ba)] == $past(q.s2.addr)))
		else $error("activate did not open row");
	chk_close_cause: assert property ((|($past(q.open) & ~q.open)) |->
		$past(close_any))
		else $error("bank closed without precharge");
	chk_pre_all: assert property ((cmd == CMD_PRE && q.s2.addr[A10_POS] &&
		q.mode == BURST_IDLE) |=> q.open == '0)
		else $error("precharge all left a bank open");
	chk_burst_len: assert property ((cmd == CMD_RD && otf_en_i &&
		q.open[q.s2.ba] && q.mode == BURST_IDLE) |=>
		q.burst_bc4 == !$past(q.s2.addr[A12_POS]))
		else $error("read chop selection wrong");
	chk_rd_no_abort: assert property ((q.mode == BURST_RD &&
		!(rd_push && rd_beat.last)) |=> q.mode == BURST_RD)
		else $error("read burst interrupted");
	chk_ap_close: assert property ((rd_push && rd_beat.last && q.burst_ap)
		|=> (!q.open[$past(q.burst_bank)] &&
		q.prech_cnt[$past(q.burst_bank)] == PRE_W'(TRP_CK)))
		else $error("auto precharge missing");
	chk_ref_step: assert property (cmd == CMD_REF |=>
		q.ref_row == $past(q.ref_row) + 1'b1)
		else $error("refresh counter did not step");
	chk_sref_hold: assert property ((q.mode == SELF_REF && !q.s2.cke) |=>
		q.mode == SELF_REF)
		else $error("self refresh left without cke");
	chk_nop_quiet: assert property ((ev && cmd == CMD_NONE &&
		q.mode == BURST_IDLE) |=> ($stable(q.open) && q.mode == BURST_IDLE))
		else $error("nop changed bank state");

	cov_rd_ap: cover property (rd_push && rd_beat.last && q.burst_ap);
	cov_rd_stall: cover property (q.mode == BURST_RD && !buf_ready);
	cov_sref: cover property ($rose(q.mode == SELF_REF));
	cov_zq_done: cover property ($fell(q.zq_busy));

endmodule

// *** verif/ddr3_ctrl_model.sv ***
`timescale 1ns/10ps
module ddr3_ctrl_model import ddr3_core_pkg::*; (
	// core clock, only used to place pin changes
	input wire logic core_clk_i,
	// command, data and calibration pins toward the device
	output pins_t pins_o
);
	pins_t p_q;

	assign pins_o = p_q;

	////////////////////////////////////////
	// idle pins: ck low and still, cke high, device deselected
	initial
	begin
		p_q = '0;
		p_q.cke = 1'b1;
		p_q.cs_b = 1'b1;
	end

	// one ck period; pins settle well before the rising edge
	task send(input logic [3:0] c, input logic k, input logic [2:0] b,
		input logic [15:0] a, input logic [15:0] d, input logic [1:0] m);
		@(negedge core_clk_i);
		{p_q.cs_b, p_q.ras_b, p_q.cas_b, p_q.we_b} = c;
		p_q.cke = k;
		p_q.ba = b;
		p_q.addr = a;
		p_q.dq = d;
		p_q.dm = m;
		#62.5 p_q.ck = 1'b1;
		#62.5 p_q.ck = 1'b0;
		// past the hold time the data lines no longer show the beat
		p_q.dq = ~d;
		p_q.dm = ~m;
	endtask

	// cke change with ck stopped, used to leave self refresh
	task hold_cke(input logic k);
		@(negedge core_clk_i);
		p_q.cs_b = 1'b1;
		p_q.cke = k;
	endtask

	// calibration comparator level
	task set_zq(input logic v);
		@(negedge core_clk_i);
		p_q.zq_hi = v;
	endtask
endmodule

// *** verif/ddr3_core_command_handling_test.sv ***
`timescale 1ns/10ps
module ddr3_core_command_handling_test import ddr3_core_pkg::*;;
	localparam logic [3:0] C_ACT = 4'h3;
	localparam logic [3:0] C_RD = 4'h5;
	localparam logic [3:0] C_WR = 4'h4;
	localparam logic [3:0] C_PRE = 4'h2;
	localparam logic [3:0] C_REF = 4'h1;
	localparam logic [3:0] C_ZQ = 4'h6;
	localparam logic [3:0] C_DES = 4'hF;

	logic core_clk_i, rst_b_i, otf_en_i, bc4_fixed_i, burst_ilv_i, rd_ready_i;
	pins_t pins;
	logic [DQ_W-1:0] rd_data_o;
	logic rd_last_o, rd_valid_o, self_ref_o, zq_busy_o, cmd_err_o;
	logic [NUM_BANKS-1:0] bank_open_o;
	logic [7:0] zq_code_o;
	logic [REF_ROW_W-1:0] refresh_row_o, r;
	logic [17:0] stat;
	logic [15:0] mem_q [8];
	int n_fail;
	int comparisons;

	assign stat = {7'h00, cmd_err_o, self_ref_o, zq_busy_o, bank_open_o};

	////////////////////////////////////////
	// clock, partner and device
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	ddr3_ctrl_model u_ddr3_ctrl_model (.core_clk_i(core_clk_i), .pins_o(pins));

	ddr3_core_cmd #(.TRP_CK(2)) u_ddr3_core_cmd (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ck_i(pins.ck),
		.cke_i(pins.cke), .cs_b_i(pins.cs_b), .ras_b_i(pins.ras_b),
		.cas_b_i(pins.cas_b), .we_b_i(pins.we_b), .ba_i(pins.ba),
		.addr_i(pins.addr), .dq_i(pins.dq), .dm_i(pins.dm),
		.zq_hi_i(pins.zq_hi), .otf_en_i(otf_en_i), .bc4_fixed_i(bc4_fixed_i),
		.burst_ilv_i(burst_ilv_i), .rd_data_o(rd_data_o),
		.rd_last_o(rd_last_o), .rd_valid_o(rd_valid_o),
		.rd_ready_i(rd_ready_i), .bank_open_o(bank_open_o),
		.self_ref_o(self_ref_o), .zq_busy_o(zq_busy_o), .zq_code_o(zq_code_o),
		.refresh_row_o(refresh_row_o), .cmd_err_o(cmd_err_o));

	////////////////////////////////////////
	// helpers
	task chk(input string name, input logic [17:0] exp, input logic [17:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task finish_test;
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// command with cke high on its edge
	task cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
		u_ddr3_ctrl_model.send(c, 1'b1, b, a, 16'h0000, 2'h0);
	endtask

	task des(input int n);
		for (int i = 0; i < n; i++)
			cmd(C_DES, 3'h0, 16'h0000);
	endtask

	// write burst to bank 2 from column 0, one masked beat per edge
	task wr(input logic [15:0] a, input logic [15:0] base, input logic [15:0] msk);
		logic [15:0] d;
		logic [1:0] m;
		cmd(C_WR, 3'h2, a);
		for (int n = 0; n < 8; n++)
		begin
			d = base + 16'(n);
			m = msk[2 * n +: 2];
			u_ddr3_ctrl_model.send(C_DES, 1'b1, 3'h0, 16'h0000, d, m);
			if (!m[0])
				mem_q[n][7:0] = d[7:0];
			if (!m[1])
				mem_q[n][15:8] = d[15:8];
		end
	endtask

	// take n beats after a stall, then see that no extra beat follows
	task rd_check(input int n, input logic [2:0] s, input logic bc4,
		input logic ilv);
		int w;
		logic [2:0] c;
		logic [2:0] i3;
		@(negedge core_clk_i);
		rd_ready_i = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			w = 0;
			while (rd_valid_o !== 1'b1 && w < 50)
			begin
				@(negedge core_clk_i);
				w++;
			end
			i3 = 3'(i);
			c = ilv ? s ^ i3 : bc4 ? {s[2], s[1:0] + i3[1:0]} : s + i3;
			chk("read_beat", {1'b1, i3 == 3'(n - 1), mem_q[c]},
				{rd_valid_o, rd_last_o, rd_data_o});
			@(negedge core_clk_i);
		end
		rd_ready_i = 1'b0;
		repeat (10) @(negedge core_clk_i);
		chk("read_drained", 18'h00000, 18'(rd_valid_o));
	endtask

	////////////////////////////////////////
	// scenarios
	task t_reset;
		@(negedge core_clk_i);
		chk("status", 18'h00000, stat);
		chk("zq_code", 18'h00080, 18'(zq_code_o));
		chk("refresh_row", 18'h00000, 18'(refresh_row_o));
	endtask

	task t_rw;
		// first ck edge after reset has no cke history, so it carries nothing
		des(1);
		cmd(C_ACT, 3'h2, 16'h0001);
		@(negedge core_clk_i);
		chk("status", 18'h00004, stat);
		wr(16'h1000, 16'h1100, 16'h0000);
		wr(16'h1000, 16'hA2C4, 16'h9C36);
		cmd(C_RD, 3'h2, 16'h1000);
		rd_check(8, 3'h0, 1'b0, 1'b0);
		cmd(C_RD, 3'h2, 16'h0005);
		rd_check(4, 3'h5, 1'b1, 1'b0);
		burst_ilv_i = 1'b1;
		cmd(C_RD, 3'h2, 16'h1403);
		rd_check(8, 3'h3, 1'b0, 1'b1);
		burst_ilv_i = 1'b0;
		chk("status", 18'h00000, stat);
	endtask

	task t_pre;
		des(2);
		cmd(C_PRE, 3'h5, 16'h0000);
		cmd(C_ACT, 3'h2, 16'h0001);
		cmd(C_ACT, 3'h6, 16'h0002);
		@(negedge core_clk_i);
		chk("status", 18'h00044, stat);
		cmd(C_PRE, 3'h6, 16'h0000);
		@(negedge core_clk_i);
		chk("status", 18'h00004, stat);
		otf_en_i = 1'b0;
		bc4_fixed_i = 1'b1;
		cmd(C_RD, 3'h2, 16'h1000);
		rd_check(4, 3'h0, 1'b1, 1'b0);
		otf_en_i = 1'b1;
		bc4_fixed_i = 1'b0;
		cmd(C_PRE, 3'h6, 16'h0400);
		@(negedge core_clk_i);
		chk("status", 18'h00000, stat);
	endtask

	task t_ref;
		des(2);
		@(negedge core_clk_i);
		r = refresh_row_o;
		cmd(C_REF, 3'h7, 16'hFFFF);
		des(4);
		cmd(C_REF, 3'h0, 16'h0000);
		des(4);
		@(negedge core_clk_i);
		chk("refresh_row", 18'(r + 13'h0002), 18'(refresh_row_o));
		chk("status", 18'h00000, stat);
	endtask

	task t_zq;
		u_ddr3_ctrl_model.set_zq(1'b1);
		cmd(C_ZQ, 3'h0, 16'h0000);
		des(63);
		@(negedge core_clk_i);
		chk("status", 18'h00100, stat);
		chk("zq_code", 18'h00080, 18'(zq_code_o));
		des(1);
		@(negedge core_clk_i);
		chk("status", 18'h00000, stat);
		chk("zq_code", 18'h000C0, 18'(zq_code_o));
	endtask

	task t_sref;
		r = refresh_row_o;
		u_ddr3_ctrl_model.send(C_REF, 1'b0, 3'h0, 16'h0000, 16'h0000, 2'h0);
		@(negedge core_clk_i);
		chk("status", 18'h00200, stat);
		repeat (1700) @(negedge core_clk_i);
		r = refresh_row_o - r;
		chk("sref_steps", 18'h00001, 18'(r >= 2 && r <= 4));
		u_ddr3_ctrl_model.hold_cke(1'b1);
		repeat (10) @(negedge core_clk_i);
		chk("status", 18'h00000, stat);
	endtask

	task t_err;
		cmd(C_RD, 3'h3, 16'h0000);
		@(negedge core_clk_i);
		chk("status", 18'h00400, stat);
		chk("read_valid", 18'h00000, 18'(rd_valid_o));
		// second reset clears the sticky error and restores reset values
		rst_b_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		t_reset;
		des(1);
		// precharge of an idle bank still restarts its precharge timer
		cmd(C_PRE, 3'h5, 16'h0000);
		cmd(C_ACT, 3'h5, 16'h0003);
		@(negedge core_clk_i);
		chk("status", 18'h00400, stat);
	endtask

	////////////////////////////////////////
	// main sequence: reset for five cycles, then each scenario
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		rst_b_i = 1'b0;
		otf_en_i = 1'b1;
		bc4_fixed_i = 1'b0;
		burst_ilv_i = 1'b0;
		rd_ready_i = 1'b0;
		repeat (5) @(negedge core_clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		t_reset;
		t_rw;
		t_pre;
		t_ref;
		t_zq;
		t_sref;
		t_err;
		finish_test;
	end

	// watchdog: scenarios need about 33 us, allow well over twice that
	initial
	begin
		#100000;
		n_fail++;
		finish_test;
	end
endmodule
